// *** dasc_capture.v ***
`timescale 1ns/1ps
`include "dasc_regs.vh"

module dasc_capture #(
  parameter SAMPLE_W  = `DASC_SAMPLE_W,
  parameter RDY_DELAY = `DASC_RDY_DELAY
) (
  input  wire                clk_sys_i,
  input  wire                reset_n_i,
  input  wire                samp_clk_i,
  input  wire [SAMPLE_W-1:0] chan1_analog_i,
  input  wire                chan1_analog_over_i,
  input  wire [SAMPLE_W-1:0] chan2_analog_i,
  input  wire                chan2_analog_over_i,
  input  wire                out_ready_i,
  output reg  [SAMPLE_W-1:0] chan1_sample_word_o,
  output reg                 chan1_sample_ready_strobe_o,
  output reg                 chan1_overrange_flag_o,
  output reg  [SAMPLE_W-1:0] chan2_sample_word_o,
  output reg                 chan2_sample_ready_strobe_o,
  output reg                 chan2_overrange_flag_o,
  output reg                 in_ready_o
);

  // Overrange when the converter flags saturation or the code sits at the negative rail (14'h2000); the positive rail 14'h1fff is not flagged.
  function over_range;
    input [SAMPLE_W-1:0] word;
    input                flag;
    begin
      over_range = flag ||
                   ($signed(word) > $signed(`DASC_FULL_POS)) ||
                   ($signed(word) < $signed(`DASC_FULL_NEG));
    end
  endfunction

  // Link clock and all converter inputs pass two flip-flops first.
  reg                samp_clk_s1_r;
  reg                samp_clk_s2_r;
  reg                samp_clk_s3_r;
  reg [SAMPLE_W-1:0] ch1_s1_r;
  reg [SAMPLE_W-1:0] ch1_s2_r;
  reg [SAMPLE_W-1:0] ch2_s1_r;
  reg [SAMPLE_W-1:0] ch2_s2_r;
  reg                ov1_s1_r;
  reg                ov1_s2_r;
  reg                ov2_s1_r;
  reg                ov2_s2_r;
  reg [RDY_DELAY-1:0] rdy_dly_r;

  wire samp_rise;
  assign samp_rise = samp_clk_s2_r && !samp_clk_s3_r;

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      samp_clk_s1_r <= 1'b0;
      samp_clk_s2_r <= 1'b0;
      samp_clk_s3_r <= 1'b0;
      ch1_s1_r      <= `DASC_ZERO_WORD;
      ch1_s2_r      <= `DASC_ZERO_WORD;
      ch2_s1_r      <= `DASC_ZERO_WORD;
      ch2_s2_r      <= `DASC_ZERO_WORD;
      ov1_s1_r      <= 1'b0;
      ov1_s2_r      <= 1'b0;
      ov2_s1_r      <= 1'b0;
      ov2_s2_r      <= 1'b0;
      rdy_dly_r     <= {RDY_DELAY{1'b1}};
    end else begin
      samp_clk_s1_r <= samp_clk_i;
      samp_clk_s2_r <= samp_clk_s1_r;
      samp_clk_s3_r <= samp_clk_s2_r;
      ch1_s1_r      <= chan1_analog_i;
      ch1_s2_r      <= ch1_s1_r;
      ch2_s1_r      <= chan2_analog_i;
      ch2_s2_r      <= ch2_s1_r;
      ov1_s1_r      <= chan1_analog_over_i;
      ov1_s2_r      <= ov1_s1_r;
      ov2_s1_r      <= chan2_analog_over_i;
      ov2_s2_r      <= ov2_s1_r;
      // Delay line keeps every edge of the inverted clock, so the strobe is high while the sample clock was low.
      rdy_dly_r     <= {rdy_dly_r[RDY_DELAY-2:0], ~samp_clk_s2_r};
    end
  end

  // Both channels' words and flags travel together through the buffer.
  localparam BW = 2 * SAMPLE_W + 2;

  wire [BW-1:0] buf_in;
  wire [BW-1:0] buf_out;
  wire          buf_in_ready;
  wire          buf_out_valid;

  assign buf_in = {ov2_s2_r, ch2_s2_r, ov1_s2_r, ch1_s2_r};

  dasc_skid_buf #(
    .WIDTH (BW)
  ) u_buf (
    .clk_sys_i   (clk_sys_i),
    .reset_n_i   (reset_n_i),
    .in_data_i   (buf_in),
    .in_valid_i  (samp_rise),
    .in_ready_o  (buf_in_ready),
    .out_data_o  (buf_out),
    .out_valid_o (buf_out_valid),
    .out_ready_i (out_ready_i)
  );

  wire [SAMPLE_W-1:0] ch1_word;
  wire [SAMPLE_W-1:0] ch2_word;
  wire                ch1_ov;
  wire                ch2_ov;

  assign ch1_word = buf_out[SAMPLE_W-1:0];
  assign ch1_ov   = buf_out[SAMPLE_W];
  assign ch2_word = buf_out[2*SAMPLE_W:SAMPLE_W+1];
  assign ch2_ov   = buf_out[BW-1];

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chan1_sample_word_o         <= `DASC_ZERO_WORD;
      chan2_sample_word_o         <= `DASC_ZERO_WORD;
      chan1_overrange_flag_o      <= 1'b0;
      chan2_overrange_flag_o      <= 1'b0;
      chan1_sample_ready_strobe_o <= 1'b1;
      chan2_sample_ready_strobe_o <= 1'b1;
      in_ready_o                  <= 1'b1;
    end else begin
      in_ready_o                  <= buf_in_ready;
      chan1_sample_ready_strobe_o <= rdy_dly_r[RDY_DELAY-1];
      chan2_sample_ready_strobe_o <= rdy_dly_r[RDY_DELAY-1];
      if (buf_out_valid && out_ready_i) begin
        chan1_sample_word_o    <= ch1_word;
        chan2_sample_word_o    <= ch2_word;
        chan1_overrange_flag_o <= over_range(ch1_word, ch1_ov);
        chan2_overrange_flag_o <= over_range(ch2_word, ch2_ov);
      end
    end
  end

endmodule

// *** dasc_regs.vh ***
`ifndef DASC_REGS_VH
`define DASC_REGS_VH

`define DASC_SAMPLE_W      14
`define DASC_SAMPLE_MSB    13
`define DASC_FULL_POS      14'sh1fff
`define DASC_FULL_NEG      -14'sh1fff
`define DASC_RDY_DELAY     2
`define DASC_ZERO_WORD     14'h0000
`define DASC_BUF_DEPTH     2

`endif

// *** dasc_skid_buf.v ***
`timescale 1ns/1ps
`include "dasc_regs.vh"

// Two-entry buffer; in_ready falls only when both entries are occupied.
module dasc_skid_buf #(
  parameter WIDTH = 15
) (
  input  wire             clk_sys_i,
  input  wire             reset_n_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);

  reg [WIDTH-1:0] mem_r [0:1];
  reg             wr_ptr_r;
  reg             rd_ptr_r;
  reg [1:0]       count_r;

  wire push;
  wire pop;

  assign in_ready_o  = (count_r != 2'd2);
  assign out_valid_o = (count_r != 2'd0);
  assign out_data_o  = mem_r[rd_ptr_r];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'd0;
      mem_r[0] <= {WIDTH{1'b0}};
      mem_r[1] <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem_r[wr_ptr_r] <= in_data_i;
        wr_ptr_r        <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      if (push && !pop) begin
        count_r <= count_r + 2'd1;
      end else if (pop && !push) begin
        count_r <= count_r - 2'd1;
      end
    end
  end

endmodule

// *** dasc_capture_checker.sv ***
`timescale 1ns/1ps
module dasc_capture_checker (
  input wire        clk_sys_i,
  input wire        reset_n_i,
  input wire        samp_clk_i,
  input wire        out_ready_i,
  input wire [13:0] chan1_sample_word_o,
  input wire        chan1_sample_ready_strobe_o,
  input wire        chan1_overrange_flag_o,
  input wire        chan2_sample_ready_strobe_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_word_hold: assert property ($changed(chan1_sample_word_o) |-> $past(out_ready_i))
    else $error("word moved without ready");
  a_strobe_delay: assert property (chan1_sample_ready_strobe_o == !$past(samp_clk_i, 5))
    else $error("strobe not inverted delayed clock");
  a_duty_follow: assert property ($fell(chan1_sample_ready_strobe_o) |->
    $past(samp_clk_i, 5) && !$past(samp_clk_i, 6))
    else $error("strobe edge without clock edge");
  a_over_rail: assert property (chan1_sample_word_o == 14'h2000 |-> chan1_overrange_flag_o)
    else $error("overrange low beyond full scale");
  a_chan_pair: assert property (chan2_sample_ready_strobe_o == chan1_sample_ready_strobe_o)
    else $error("channel strobes differ");
endmodule

bind dasc_capture dasc_capture_checker chk (.clk_sys_i, .reset_n_i, .samp_clk_i, .out_ready_i,
  .chan1_sample_word_o, .chan1_sample_ready_strobe_o, .chan1_overrange_flag_o,
  .chan2_sample_ready_strobe_o);

// *** dasc_rx_model.sv ***
`timescale 1ns/1ps
module dasc_rx_model (
  input  wire        clk_sys_i,
  input  wire        reset_n_i,
  input  wire        stall_i,
  input  wire [13:0] word1_i,
  input  wire [13:0] word2_i,
  input  wire        rdy_strobe_i,
  output wire        ready_o,
  output reg  [13:0] cap1_o,
  output reg  [13:0] cap2_o
);
  reg strobe_prev_r;
  assign ready_o = !stall_i;
  // The strobe idles high after reset, so the edge memory starts high to avoid a false edge.
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cap1_o        <= 14'h0000;
      cap2_o        <= 14'h0000;
      strobe_prev_r <= 1'b1;
    end else begin
      strobe_prev_r <= rdy_strobe_i;
      // Words settle well before the strobe rises, half a sampling period later.
      if (rdy_strobe_i && !strobe_prev_r) begin
        cap1_o <= word1_i;
        cap2_o <= word2_i;
      end
    end
  end
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  reg         clk_sys_i = 0, reset_n_i = 0, samp_clk_i = 0, stall = 0, o1 = 0, o2 = 0;
  reg  [13:0] a1 = 0, a2 = 0;
  wire [13:0] w1, w2, c1, c2;
  wire        s1, s2, f1, f2, rdy, inr;
  integer     error_cnt = 0, tests_run = 0, cyc = 0;
  dasc_capture dut (.clk_sys_i, .reset_n_i, .samp_clk_i, .chan1_analog_i(a1),
    .chan1_analog_over_i(o1), .chan2_analog_i(a2), .chan2_analog_over_i(o2), .out_ready_i(rdy),
    .chan1_sample_word_o(w1), .chan1_sample_ready_strobe_o(s1), .chan1_overrange_flag_o(f1),
    .chan2_sample_word_o(w2), .chan2_sample_ready_strobe_o(s2), .chan2_overrange_flag_o(f2),
    .in_ready_o(inr));
  dasc_rx_model rx (.clk_sys_i, .reset_n_i, .stall_i(stall), .word1_i(w1), .word2_i(w2),
    .rdy_strobe_i(s1), .ready_o(rdy), .cap1_o(c1), .cap2_o(c2));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  // A 160 ns sampling period stays far below the converter's maximum rate.
  initial begin
    #200;
    forever #80 samp_clk_i = ~samp_clk_i;
  end
  task results;
    begin
      $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  always @(posedge clk_sys_i) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      error_cnt = error_cnt + 1;
      results;
    end
  end
  task chk(input [13:0] got, input [13:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task t_cap(input [13:0] v1, input [13:0] v2, input ov1, input ov2, input e1, input e2);
    begin
      @(posedge clk_sys_i);
      #1;
      a1 = v1;
      a2 = v2;
      o1 = ov1;
      o2 = ov2;
      repeat (40) @(posedge clk_sys_i);
      chk(c1, v1);
      chk(c2, v2);
      chk({13'h0000, f1}, {13'h0000, e1});
      chk({13'h0000, f2}, {13'h0000, e2});
      $display("capture test done");
    end
  endtask
  // Stalled receiver: buffer must fill and refuse, then drain without losing the new word.
  task t_stall;
    begin
      @(posedge clk_sys_i);
      #1;
      stall = 1;
      a1 = 14'h0abc;
      repeat (80) @(posedge clk_sys_i);
      chk({13'h0000, inr}, 14'h0000);
      chk(c1, 14'h1fff);
      #1 stall = 0;
      repeat (40) @(posedge clk_sys_i);
      chk(c1, 14'h0abc);
      $display("stall test done");
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_i);
    #1 reset_n_i = 1;
    chk(c1, 14'h0000);
    t_cap(14'h1234, 14'h2000, 1'b0, 1'b0, 1'b0, 1'b1);
    t_cap(14'h2000, 14'h1fff, 1'b0, 1'b0, 1'b1, 1'b0);
    t_cap(14'h1fff, 14'h0005, 1'b0, 1'b1, 1'b0, 1'b1);
    t_stall;
    results;
  end
endmodule
